// [hotplug_pkg.sv]
// constants and types for the single-slot hot-plug slot controller
// Contract
// R1: single-slot no-switch mode only when all four slot-count straps read high at reset
// R2: while disconnected in single-slot mode, ground all bus, reset and wake signals
// R3: ground the five slot clocks while disconnected; the feedback clock always runs
// R4: first reconnection stage applies slot power with every bus signal still grounded
// R5: after an interval, release slot clocks to toggle, except firmware-disabled ones
// R6: after a further interval, drive data lines to default values; slot reset stays low
// R7: at bus connect, pulse control lines high for one clock, then release them
// R8: at bus connect, release the wake line and the eight interrupt pins
// R9: after a final interval, drive slot reset continuously high
// R10: master-abort outbound traffic to the segment while the slot is disconnected
// R11: debounce switch inputs; accept a change only after 8 ms of stability
// R12: any switch change before the interval ends restarts the debounce count
// R13: on controller reset assert slot reset, remove power, turn indicators off
// R14: initialize the segment in 33 MHz conventional mode with the slot isolated
// R15: never drive the 66 MHz capability pin while the slot is disconnected
// R16: deliver interrupts by message or router input 23, never both, by enable bit
// R17: send a message interrupt only when none is already pending
// R18: steering bit 5 turns interrupts into in-band system-control messages instead
// R19: steering sends assert on rising interrupt edge, deassert on falling edge
// R20: requester identifier of these messages uses primary bus number zero
// R21: with fault detection enabled, a power fault asserts reset and disconnects the slot
// R22: latch opening mid-sequence finishes the step, then powers down within 320 ms
// R23: stage intervals are parameterized cycle counts
package hotplug_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int FB_PERIOD_NS = 800;
	localparam int DEBOUNCE_MS = 8;
	localparam int PWR_TO_CLK_US = 100000;
	localparam int CLK_TO_BUS_US = 1000;
	localparam int BUS_TO_RST_US = 1000;
	localparam int AUTO_OFF_MS = 320;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWR_TO_CLK_CYC = (PWR_TO_CLK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLK_TO_BUS_CYC = (CLK_TO_BUS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_TO_RST_CYC = (BUS_TO_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUTO_OFF_CYC = AUTO_OFF_MS * 1000000 / CLK_PERIOD_NS;
	localparam int FB_HALF_CYC = FB_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int CNT_W = 24;
	localparam logic [3:0] STRAP_SINGLE = 4'hF;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EVENT = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0C;
	// control fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_FAULT_EN = 1;
	localparam int CTL_MSI_EN = 2;
	localparam int CTL_ATTN = 3;
	localparam int CTL_STEER = 5;
	localparam int CTL_CLKDIS_LSB = 8;
	localparam int CTL_MODE_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_RW_MASK = 32'h0003_1F2F;
	localparam logic [1:0] MODE_33_CONV = 2'h0;
	// event bits
	localparam int EVT_SWITCH = 0;
	localparam int EVT_FAULT = 1;
	localparam int EVT_ON = 2;
	localparam int EVT_LATCH = 3;
	localparam int NUM_EVT = 4;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// status fields
	localparam int STS_STATE_LSB = 0;
	localparam int STS_SW_LSB = 4;
	localparam int STS_FAULT = 8;
	localparam int STS_SPEED_SENSE = 9;
	localparam int STS_SPEED_CAP = 10;
	localparam int STS_PME = 11;
	localparam int STS_SINGLE = 12;
	localparam int STS_HP_EN = 13;
	localparam int STS_PENDING = 14;
	// message identity
	localparam logic [7:0] PRIMARY_BUS = 8'h00;
	localparam logic [7:0] BRIDGE_DEVFN = 8'h00;

	typedef enum logic [2:0] {ST_OFF, ST_POWER, ST_CLOCK, ST_BUS, ST_ON, ST_FAULT} slot_state_t;
	typedef enum logic [1:0] {PH_GROUND, PH_WAIT, PH_HIGH, PH_FREE} ctl_phase_t;
	typedef struct packed {
		logic [63:0] ad;
		logic [7:0] cbe_n;
		logic par;
		logic par64;
		logic req64_n;
		logic ack64_n;
	} data_pins_t;
	typedef struct packed {
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic stop_n;
		logic devsel_n;
		logic lock_n;
		logic [3:0] gnt_n;
		logic [3:0] req_n;
		logic perr_n;
		logic serr_n;
	} ctl_pins_t;
	typedef struct packed {
		logic latch_n;
		logic button_n;
		logic [1:0] present_n;
	} switch_t;
	typedef struct packed {
		logic assert_gpe;
		logic [15:0] requester_id;
	} gpe_msg_t;
	localparam data_pins_t DATA_PARK = '{ad: 64'h0, cbe_n: 8'h00, par: 1'b0, par64: 1'b0,
		req64_n: 1'b1, ack64_n: 1'b1};
endpackage

// [single_slot_hotplug_control.sv]
// single-slot hot-plug sequencer, pin control and interrupt delivery
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module single_slot_hotplug_control #(
	parameter int DEBOUNCE_CYC = hotplug_pkg::DEBOUNCE_CYC,
	parameter int PWR_CLK_CYC = hotplug_pkg::PWR_TO_CLK_CYC,
	parameter int CLK_BUS_CYC = hotplug_pkg::CLK_TO_BUS_CYC,
	parameter int BUS_RST_CYC = hotplug_pkg::BUS_TO_RST_CYC,
	parameter int FB_HALF_CYC = hotplug_pkg::FB_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic [3:0] slot_count_strap,
	input wire logic feedback_clock_in,
	output logic feedback_clock_out,
	output logic [4:0] slot_clock_out,
	input wire hotplug_pkg::switch_t slot_switch_n,
	input wire logic slot_power_fault_n,
	input wire logic slot_speed_sense,
	output logic slot_power_enable,
	output logic slot_reset_out_n,
	output logic power_indicator_n,
	output logic attention_indicator_n,
	output hotplug_pkg::data_pins_t data_out,
	output hotplug_pkg::data_pins_t data_oe,
	output hotplug_pkg::ctl_pins_t ctl_out,
	output hotplug_pkg::ctl_pins_t ctl_oe,
	input wire logic pme_in,
	output logic pme_out,
	output logic pme_oe,
	input wire logic [7:0] external_irq_in,
	output logic [7:0] external_irq_out,
	output logic [7:0] external_irq_oe,
	input wire logic slot_speed_capable_in,
	output logic slot_speed_capable_out,
	output logic slot_speed_capable_oe,
	output logic master_abort_outbound,
	output logic [1:0] bus_mode,
	output logic router_irq23,
	output logic msi_req,
	output logic sci_forward_message,
	output hotplug_pkg::gpe_msg_t gpe_msg
);
	localparam int CW = hotplug_pkg::CNT_W;

	// refuse counts the counters cannot hold or that break the power-down bound
	if (DEBOUNCE_CYC < 1 || PWR_CLK_CYC < 1 || CLK_BUS_CYC < 1 || BUS_RST_CYC < 1 ||
		DEBOUNCE_CYC >= 2**CW || PWR_CLK_CYC >= 2**CW || CLK_BUS_CYC >= 2**CW ||
		BUS_RST_CYC >= 2**CW || FB_HALF_CYC < 1 || FB_HALF_CYC > 255 ||
		PWR_CLK_CYC + CLK_BUS_CYC + BUS_RST_CYC >= hotplug_pkg::AUTO_OFF_CYC) begin : g_bad_params
		$error("hot-plug controller parameters out of range");
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// two-flop synchronisers for everything arriving from pins
	logic [8:0] sync_meta;
	logic [8:0] sync_q;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// idle pin levels: link clock low to match fb_prev, fault and wake inactive
			sync_meta <= 9'h0F9;
			sync_q <= 9'h0F9;
		end else begin
			sync_meta <= {feedback_clock_in, slot_switch_n, slot_power_fault_n, slot_speed_sense,
				slot_speed_capable_in, pme_in};
			sync_q <= sync_meta;
		end
	end
	logic fb_s;
	hotplug_pkg::switch_t sw_s;
	logic fault_n_s;
	assign fb_s = sync_q[8];
	assign sw_s = sync_q[7:4];
	assign fault_n_s = sync_q[3];

	// strap capture once the synchroniser holds a clean sample
	logic [3:0] strap_meta;
	logic [3:0] strap_s;
	logic [1:0] strap_wait;
	logic single_mode;
	logic hp_enabled;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strap_meta <= 4'h0;
			strap_s <= 4'h0;
		end else begin
			strap_meta <= slot_count_strap;
			strap_s <= strap_meta;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			strap_wait <= 2'h0;
			single_mode <= 1'b0;
			hp_enabled <= 1'b0;
		end else if (strap_wait != 2'h3) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == 2'h2) begin
				single_mode <= (strap_s == hotplug_pkg::STRAP_SINGLE); // [R1]
				hp_enabled <= strap_s[3];
			end
		end
	end

	// switch debounce: any wiggle restarts the count
	hotplug_pkg::switch_t sw_prev;
	hotplug_pkg::switch_t sw_stable;
	hotplug_pkg::switch_t sw_stable_d;
	logic [CW-1:0] deb_cnt;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sw_prev <= 4'hF;
			sw_stable <= 4'hF;
			sw_stable_d <= 4'hF;
			deb_cnt <= '0;
		end else begin
			sw_prev <= sw_s;
			sw_stable_d <= sw_stable;
			if (sw_s != sw_prev) begin
				deb_cnt <= '0; // [R12]
			end else if (deb_cnt == CW'(DEBOUNCE_CYC - 1)) begin
				sw_stable <= sw_prev; // [R11]
			end else begin
				deb_cnt <= deb_cnt + 1'b1;
			end
		end
	end
	logic latch_open;
	logic card_present;
	assign latch_open = sw_stable.latch_n;
	assign card_present = (sw_stable.present_n != 2'b11);

	// software registers
	logic [31:0] ctrl;
	logic [3:0] mask;
	logic [3:0] events;
	logic auto_off;
	logic wr_ctrl;
	assign wr_ctrl = reg_write && (reg_addr == hotplug_pkg::REG_CTRL);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl <= hotplug_pkg::CTRL_RESET; // [R14]
			mask <= hotplug_pkg::MASK_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl <= reg_wdata & hotplug_pkg::CTRL_RW_MASK;
			end
			// hardware power-down drops the request so the slot stays off
			if (auto_off) begin
				ctrl[hotplug_pkg::CTL_ENABLE] <= 1'b0;
			end
			if (reg_write && reg_addr == hotplug_pkg::REG_MASK) begin
				mask <= reg_wdata[3:0];
			end
		end
	end
	logic enable;
	logic fault_hit;
	logic steer;
	logic msi_en;
	assign enable = ctrl[hotplug_pkg::CTL_ENABLE];
	assign steer = ctrl[hotplug_pkg::CTL_STEER];
	assign msi_en = ctrl[hotplug_pkg::CTL_MSI_EN];
	assign fault_hit = ctrl[hotplug_pkg::CTL_FAULT_EN] && !fault_n_s;
	assign bus_mode = ctrl[hotplug_pkg::CTL_MODE_LSB +: 2]; // [R14]

	// connection sequencer: power, clock, bus, reset release
	hotplug_pkg::slot_state_t state;
	hotplug_pkg::slot_state_t state_d;
	logic [CW-1:0] seq_cnt;
	logic latch_seen;
	logic connected;
	logic clocks_on;
	assign connected = (state == hotplug_pkg::ST_BUS) || (state == hotplug_pkg::ST_ON);
	assign clocks_on = connected || (state == hotplug_pkg::ST_CLOCK);
	assign auto_off = (state == hotplug_pkg::ST_ON) && (latch_seen || latch_open); // [R22]
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= hotplug_pkg::ST_OFF; // [R13] [R14]
			state_d <= hotplug_pkg::ST_OFF;
			seq_cnt <= '0;
		end else begin
			state_d <= state;
			seq_cnt <= seq_cnt + 1'b1;
			case (state)
				hotplug_pkg::ST_OFF: begin
					seq_cnt <= '0;
					if (single_mode && enable && !latch_open && card_present) begin
						state <= hotplug_pkg::ST_POWER; // [R4]
					end
				end
				hotplug_pkg::ST_POWER: begin
					if (seq_cnt == CW'(PWR_CLK_CYC - 1)) begin
						state <= hotplug_pkg::ST_CLOCK; // [R5] [R23]
						seq_cnt <= '0;
					end
				end
				hotplug_pkg::ST_CLOCK: begin
					if (seq_cnt == CW'(CLK_BUS_CYC - 1)) begin
						state <= hotplug_pkg::ST_BUS; // [R6] [R23]
						seq_cnt <= '0;
					end
				end
				hotplug_pkg::ST_BUS: begin
					if (seq_cnt == CW'(BUS_RST_CYC - 1)) begin
						state <= hotplug_pkg::ST_ON; // [R9] [R23]
					end
				end
				hotplug_pkg::ST_ON: begin
					if (auto_off) begin
						state <= hotplug_pkg::ST_OFF; // [R22]
					end
				end
				default: begin
					// fault holds the slot isolated until software drops the request
					if (!enable) begin
						state <= hotplug_pkg::ST_OFF;
					end
				end
			endcase
			if (fault_hit && state != hotplug_pkg::ST_OFF && state != hotplug_pkg::ST_FAULT) begin
				state <= hotplug_pkg::ST_FAULT; // [R21]
			end else if (!enable && state != hotplug_pkg::ST_FAULT) begin
				state <= hotplug_pkg::ST_OFF;
			end
		end
	end

	// remember a latch opening seen while a step is in progress
	always_ff @(posedge sys_clk) begin
		if (!rst_n || state == hotplug_pkg::ST_OFF) begin
			latch_seen <= 1'b0;
		end else if (latch_open) begin
			latch_seen <= 1'b1; // [R22]
		end
	end

	// slot pins, registered so the board sees clean levels
	logic grounded;
	assign grounded = single_mode && !connected;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			slot_power_enable <= 1'b0; // [R13]
			slot_reset_out_n <= 1'b0;
			power_indicator_n <= 1'b1;
			attention_indicator_n <= 1'b1;
			data_out <= '0;
			data_oe <= '0;
			pme_oe <= 1'b0;
			external_irq_oe <= 8'h00;
			master_abort_outbound <= 1'b0;
		end else begin
			// power stays on through a fault: only software removes it
			slot_power_enable <= (state != hotplug_pkg::ST_OFF); // [R4]
			slot_reset_out_n <= (state == hotplug_pkg::ST_ON); // [R9] [R21]
			power_indicator_n <= (state != hotplug_pkg::ST_ON);
			attention_indicator_n <= !ctrl[hotplug_pkg::CTL_ATTN];
			data_oe <= {$bits(hotplug_pkg::data_pins_t){single_mode}}; // [R2]
			data_out <= connected ? hotplug_pkg::DATA_PARK : '0; // [R6]
			pme_oe <= grounded; // [R8]
			external_irq_oe <= {8{grounded}}; // [R8]
			master_abort_outbound <= grounded; // [R10]
		end
	end
	assign pme_out = 1'b0;
	assign external_irq_out = 8'h00;
	// capability pin is only ever sensed, so the card can pull it while powered
	assign slot_speed_capable_out = 1'b0;
	assign slot_speed_capable_oe = 1'b0; // [R15]

	// control lines: grounded, then high for one link clock, then released
	hotplug_pkg::ctl_phase_t ctl_phase;
	logic fb_prev;
	logic fb_rise;
	assign fb_rise = fb_s && !fb_prev;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fb_prev <= 1'b0;
			ctl_phase <= hotplug_pkg::PH_GROUND;
		end else begin
			fb_prev <= fb_s;
			if (!connected) begin
				ctl_phase <= hotplug_pkg::PH_GROUND; // [R2]
			end else begin
				case (ctl_phase)
					hotplug_pkg::PH_GROUND: ctl_phase <= hotplug_pkg::PH_WAIT;
					hotplug_pkg::PH_WAIT: if (fb_rise) ctl_phase <= hotplug_pkg::PH_HIGH; // [R7]
					hotplug_pkg::PH_HIGH: if (fb_rise) ctl_phase <= hotplug_pkg::PH_FREE; // [R7]
					default: ctl_phase <= hotplug_pkg::PH_FREE;
				endcase
			end
		end
	end
	assign ctl_oe = {$bits(hotplug_pkg::ctl_pins_t){single_mode && ctl_phase != hotplug_pkg::PH_FREE}};
	assign ctl_out = {$bits(hotplug_pkg::ctl_pins_t){ctl_phase == hotplug_pkg::PH_HIGH}};

	// slot clocks follow the link clock from the clock stage on; feedback clock never stops
	logic [7:0] fb_div;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			slot_clock_out <= 5'h00;
			fb_div <= 8'h00;
			feedback_clock_out <= 1'b0;
		end else begin
			slot_clock_out <= clocks_on ? ({5{fb_s}} & ~ctrl[hotplug_pkg::CTL_CLKDIS_LSB +: 5]) : 5'h00; // [R3] [R5]
			if (fb_div == 8'(FB_HALF_CYC - 1)) begin
				fb_div <= 8'h00;
				feedback_clock_out <= !feedback_clock_out; // [R3]
			end else begin
				fb_div <= fb_div + 8'h01;
			end
		end
	end

	// sticky events; a set in the clearing cycle survives
	logic [3:0] evt_set;
	logic [3:0] evt_clr;
	logic ctrl_irq;
	logic irq_d;
	always_comb begin
		evt_set = 4'h0;
		evt_set[hotplug_pkg::EVT_SWITCH] = (sw_stable != sw_stable_d);
		evt_set[hotplug_pkg::EVT_FAULT] = (state == hotplug_pkg::ST_FAULT) && (state_d != hotplug_pkg::ST_FAULT);
		evt_set[hotplug_pkg::EVT_ON] = (state == hotplug_pkg::ST_ON) && (state_d != hotplug_pkg::ST_ON);
		evt_set[hotplug_pkg::EVT_LATCH] = auto_off;
		evt_clr = (reg_write && reg_addr == hotplug_pkg::REG_EVENT) ? reg_wdata[3:0] : 4'h0;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			events <= 4'h0;
		end else begin
			events <= (events & ~evt_clr) | evt_set;
		end
	end
	assign ctrl_irq = |(events & mask);

	// delivery: steering message, else message interrupt, else router input 23
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_d <= 1'b0;
			msi_req <= 1'b0;
			router_irq23 <= 1'b0;
			sci_forward_message <= 1'b0;
			gpe_msg <= '0;
		end else begin
			irq_d <= ctrl_irq;
			msi_req <= !steer && msi_en && ctrl_irq && !irq_d; // [R16] [R17]
			router_irq23 <= !steer && !msi_en && ctrl_irq; // [R16]
			sci_forward_message <= steer && (ctrl_irq != irq_d); // [R18] [R19]
			gpe_msg.assert_gpe <= ctrl_irq; // [R19]
			gpe_msg.requester_id <= {hotplug_pkg::PRIMARY_BUS, hotplug_pkg::BRIDGE_DEVFN}; // [R20]
		end
	end

	// register read port: data valid the cycle after the strobe only
	logic [31:0] status;
	always_comb begin
		status = 32'h0000_0000;
		status[hotplug_pkg::STS_STATE_LSB +: 3] = state;
		status[hotplug_pkg::STS_SW_LSB +: 4] = sw_stable;
		status[hotplug_pkg::STS_FAULT] = !fault_n_s;
		status[hotplug_pkg::STS_SPEED_SENSE] = sync_q[2];
		status[hotplug_pkg::STS_SPEED_CAP] = sync_q[1];
		status[hotplug_pkg::STS_PME] = sync_q[0];
		status[hotplug_pkg::STS_SINGLE] = single_mode;
		status[hotplug_pkg::STS_HP_EN] = hp_enabled;
		status[hotplug_pkg::STS_PENDING] = irq_d;
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !reg_read) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == hotplug_pkg::REG_CTRL) begin
			reg_rdata <= ctrl;
		end else if (reg_addr == hotplug_pkg::REG_STATUS) begin
			reg_rdata <= status;
		end else if (reg_addr == hotplug_pkg::REG_EVENT) begin
			reg_rdata <= {28'h0000000, events};
		end else if (reg_addr == hotplug_pkg::REG_MASK) begin
			reg_rdata <= {28'h0000000, mask};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// checks on sequencing, pins and delivery
	property p_strap;
		strap_wait == 2'h2 |=> single_mode == ($past(strap_s) == hotplug_pkg::STRAP_SINGLE);
	endproperty
	a_strap: assert property (p_strap) else $error("mode does not follow straps"); // [R1]
	property p_ground;
		single_mode && $past(single_mode) && !$past(connected) |->
			data_out == '0 && &data_oe && !slot_reset_out_n && pme_oe && !slot_speed_capable_oe;
	endproperty
	a_ground: assert property (p_ground) else $error("bus not grounded while disconnected"); // [R2]
	property p_clk_gnd;
		!$past(clocks_on) |-> slot_clock_out == 5'h00;
	endproperty
	a_clk_gnd: assert property (p_clk_gnd) else $error("slot clock toggles while off"); // [R3]
	property p_fb_run;
		$changed(feedback_clock_out) |=> $stable(feedback_clock_out) [*3] ##1 $changed(feedback_clock_out);
	endproperty
	a_fb_run: assert property (p_fb_run) else $error("feedback clock not running"); // [R3]
	property p_power_first;
		$past(state) == hotplug_pkg::ST_POWER |-> slot_power_enable && slot_clock_out == 5'h00 && data_out == '0;
	endproperty
	a_power_first: assert property (p_power_first) else $error("power stage not isolated"); // [R4]
	property p_interval;
		$changed(state) && state == hotplug_pkg::ST_CLOCK |-> $past(seq_cnt) == CW'(PWR_CLK_CYC - 1);
	endproperty
	a_interval: assert property (p_interval) else $error("clock stage entered early"); // [R23]
	property p_ctl_release;
		$fell(ctl_phase == hotplug_pkg::PH_HIGH) && connected |-> ctl_oe == '0 ##1 ctl_oe == '0;
	endproperty
	a_ctl_release: assert property (p_ctl_release) else $error("control lines not released"); // [R7]
	property p_release;
		single_mode && $past(connected) |-> !pme_oe && external_irq_oe == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("wake or irq pins still driven"); // [R8]
	property p_abort;
		single_mode && $past(single_mode) |-> master_abort_outbound == !$past(connected);
	endproperty
	a_abort: assert property (p_abort) else $error("outbound abort wrong"); // [R10]
	property p_deb_clear;
		sw_s != sw_prev |=> deb_cnt == '0;
	endproperty
	a_deb_clear: assert property (p_deb_clear) else $error("debounce not restarted"); // [R12]
	property p_reset_out;
		!$past(rst_n) |-> !slot_power_enable && !slot_reset_out_n && power_indicator_n && attention_indicator_n;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("slot outputs wrong after reset"); // [R13]
	property p_exclusive;
		!(msi_req && router_irq23) && !(sci_forward_message && (msi_req || router_irq23));
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("two interrupt paths at once"); // [R16]
	property p_msi;
		msi_req |-> $past(ctrl_irq) && !$past(irq_d);
	endproperty
	a_msi: assert property (p_msi) else $error("message sent while pending"); // [R17]
	property p_gpe;
		steer && $rose(ctrl_irq) |=> sci_forward_message && gpe_msg.assert_gpe && gpe_msg.requester_id[15:8] == 8'h00;
	endproperty
	a_gpe: assert property (p_gpe) else $error("assert message missing"); // [R19]
	property p_fault;
		fault_hit && state == hotplug_pkg::ST_ON |=> state == hotplug_pkg::ST_FAULT ##1 !slot_reset_out_n;
	endproperty
	a_fault: assert property (p_fault) else $error("fault did not isolate slot"); // [R21]
	c_on: cover property (state == hotplug_pkg::ST_POWER ##1 state == hotplug_pkg::ST_CLOCK);
	c_fault: cover property (state == hotplug_pkg::ST_FAULT);
	c_gpe: cover property (sci_forward_message && !gpe_msg.assert_gpe);
	c_msi: cover property (msi_req);
endmodule

// [slot_card.sv]
// add-in card model: switches, presence, fault and speed pin
`timescale 1ns/1ps
module slot_card (
	input wire logic inserted,
	input wire logic fault,
	input wire logic power,
	output hotplug_pkg::switch_t sw_n,
	output logic fault_n,
	output logic speed_pin
);
	// latch closed and card present while seated; no button fitted
	assign sw_n = '{latch_n: !inserted, button_n: 1'b1, present_n: {1'b1, !inserted}};
	// a fault can only show once the slot rail is up
	assign fault_n = !(fault && power);
	// pull-up sits on the switched slot rail
	assign speed_pin = power;
endmodule

// [tb_top.sv]
// self-checking bench for the hot-plug slot controller
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, fb_clk = 0, ins = 0, flt = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, rdata, reg_rdata;
	logic pwr, rst_o, pled, atn, fault_n, spd, spd_oe, spd_out, fb_o, abort, irq23, msi, sci, pme_oe;
	logic [4:0] sclk;
	logic [1:0] mode;
	logic [7:0] irq_oe;
	hotplug_pkg::switch_t sw_n;
	hotplug_pkg::data_pins_t d_out, d_oe;
	hotplug_pkg::ctl_pins_t c_out, c_oe;
	hotplug_pkg::gpe_msg_t gpe, last_gpe;
	int fails = 0, comparisons = 0, msis = 0, scis = 0;
	// clocks; link clock unrelated in phase
	always #50 sys_clk = ~sys_clk;
	initial #137 forever #400 fb_clk = ~fb_clk;
	// count one-cycle interrupt pulses
	always @(posedge sys_clk) begin
		if (msi === 1'b1) msis++;
		if (sci === 1'b1) begin
			scis++;
			last_gpe = gpe;
		end
	end
	slot_card u_card (.inserted(ins), .fault(flt), .power(pwr), .sw_n(sw_n), .fault_n(fault_n), .speed_pin(spd));
	single_slot_hotplug_control #(.DEBOUNCE_CYC(20), .PWR_CLK_CYC(10), .CLK_BUS_CYC(20), .BUS_RST_CYC(10)) u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .slot_count_strap(4'hF), .feedback_clock_in(fb_clk),
		.feedback_clock_out(fb_o), .slot_clock_out(sclk), .slot_switch_n(sw_n), .slot_power_fault_n(fault_n),
		.slot_speed_sense(spd), .slot_power_enable(pwr), .slot_reset_out_n(rst_o), .power_indicator_n(pled),
		.attention_indicator_n(atn), .data_out(d_out), .data_oe(d_oe), .ctl_out(c_out), .ctl_oe(c_oe),
		.pme_in(1'b1), .pme_out(), .pme_oe(pme_oe), .external_irq_in(8'hFF), .external_irq_out(),
		.external_irq_oe(irq_oe), .slot_speed_capable_in(spd), .slot_speed_capable_out(spd_out),
		.slot_speed_capable_oe(spd_oe), .master_abort_outbound(abort), .bus_mode(mode), .router_irq23(irq23),
		.msi_req(msi), .sci_forward_message(sci), .gpe_msg(gpe));
	// wide enough for the grounded data bus and its enables side by side
	task automatic check(input logic [159:0] seen, input logic [159:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// register bus: one-cycle strobes, read data in the following cycle only
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under two hundred cycles
	initial begin
		#2000000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1 check({pwr, rst_o, pled, atn}, 4'b0011);
		repeat (5) @(posedge sys_clk);
		#1 check({d_oe, d_out}, {~76'h0, 76'h0});
		check({c_oe, c_out}, 32'hFFFF_0000);
		check({sclk, abort, spd_oe, spd_out, mode}, 10'h010);
		rdata = {31'h0, fb_o};
		repeat (4) @(posedge sys_clk);
		#1 check(fb_o, !rdata[0]);
		rd(hotplug_pkg::REG_STATUS, rdata);
		check(rdata[hotplug_pkg::STS_SINGLE], 1'b1);
		rd(8'h10, rdata);
		check(rdata, 32'h0);
		// slot-on event unmasked, message interrupts on
		wr(hotplug_pkg::REG_MASK, 32'h4);
		wr(hotplug_pkg::REG_CTRL, 32'hF);
		ins <= 1'b1;
		for (int i = 0; i < 100 && pwr !== 1'b1; i++) @(posedge sys_clk);
		#1 check({pwr, sclk, d_out}, {1'b1, 81'h0});
		for (int i = 0; i < 100 && sclk === 5'h0; i++) @(posedge sys_clk);
		#1 check({rst_o, d_out}, 77'h0);
		for (int i = 0; i < 100 && d_out !== hotplug_pkg::DATA_PARK; i++) @(posedge sys_clk);
		#1 check({rst_o, pme_oe, irq_oe}, 10'h0);
		for (int i = 0; i < 20 && c_out === 16'h0; i++) @(posedge sys_clk);
		#1 check({c_oe, c_out}, 32'hFFFF_FFFF);
		for (int i = 0; i < 10 && c_oe !== 16'h0; i++) @(posedge sys_clk);
		#1 check(c_oe, 16'h0);
		for (int i = 0; i < 100 && rst_o !== 1'b1; i++) @(posedge sys_clk);
		#1 check({rst_o, abort, pled, atn}, 4'b1000);
		repeat (3) @(posedge sys_clk);
		#1 check({msis[3:0], irq23}, 5'h2);
		// steering on, then clearing the event drops the pending level
		wr(hotplug_pkg::REG_CTRL, 32'h2F);
		wr(hotplug_pkg::REG_EVENT, 32'h4);
		repeat (4) @(posedge sys_clk);
		#1 check({scis[3:0], last_gpe, msis[3:0]}, {4'h1, 17'h0, 4'h1});
		// unmasking the still-latched switch event raises the level again
		wr(hotplug_pkg::REG_MASK, 32'h5);
		repeat (3) @(posedge sys_clk);
		#1 check({scis[3:0], last_gpe, msis[3:0], irq23}, {4'h2, 1'b1, 16'h0, 4'h1, 1'b0});
		flt <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 check({rst_o, abort, d_out}, {2'b01, 76'h0});
		end_of_test();
	end
endmodule
